// *** core/cesh_pkg.sv ***
// types shared by the channel / sync config block
// assumes the constants header beside it
package cesh_pkg;
   // sync word content selection
   typedef enum logic [1:0] {
      CESH_WORD_CRC,
      CESH_WORD_FEC,
      CESH_WORD_NONE
   } cesh_word_e;
   // per-channel enables, a..d
   typedef struct packed {
      logic ch_d;
      logic ch_c;
      logic ch_b;
      logic ch_a;
   } cesh_chan_s;
   // link shape handed to the transmitter
   typedef struct packed {
      logic [3:0] lanes;
      logic [3:0] convs;
      logic tail_pad;
      logic swap_cd;
   } cesh_shape_s;
endpackage

// *** core/cesh_regs.svh ***
// offsets, field positions, reset values for the channel / sync config block
// assumes byte-wide registers on a plain strobe port, one clock
// Operation
// - single bit disables channels B, C, D
// - second pair bit gates channels C, D
// - first pair bit gates channels A, B
// - pair off halves lanes and converters
// - odd full lane count adds tail bits while a pair is off
// - first pair off moves C, D forward
// - sync select picks CRC-12 or FEC word
// - sync select only used in 64B/66B formats
// - command fields always zero, idle headers
`ifndef CESH_REGS_SVH
`define CESH_REGS_SVH
`define CESH_ADDR_W 12
`define CESH_OFF_PAIR 12'h209
`define CESH_OFF_SYNC 12'h20f
`define CESH_RST_PAIR 8'h03
`define CESH_RST_SYNC 8'h00
`define CESH_BIT_FIRST 0
`define CESH_BIT_SECOND 1
`define CESH_BIT_LONE 2
`define CESH_PAIR_MASK 8'h07
`define CESH_SYNC_MASK 8'h03
`define CESH_SH_CRC 2'h0
`define CESH_SH_FEC 2'h2
`define CESH_SYNC_WORD_W 32
`endif

// *** core/cesh_shape.sv ***
// derives link lane / converter counts from the enables
// assumes full-mode counts arrive as stable inputs
module cesh_shape #(
   parameter int CNT_W = 4
) (
   input wire logic [CNT_W-1:0] full_lanes,
   input wire logic [CNT_W-1:0] full_convs,
   input wire logic pair_off,
   output logic [CNT_W-1:0] lanes,
   output logic [CNT_W-1:0] convs,
   output logic tail_pad
);
   // refuse a width that cannot hold any count
   if (CNT_W < 2) begin : g_bad_width
      $error("cesh_shape width too small");
   end
   always_comb begin
      if (pair_off) begin
         lanes = (full_lanes >> 1) + {{(CNT_W-1){1'b0}}, full_lanes[0]};
         convs = full_convs >> 1;
      end else begin
         lanes = full_lanes;
         convs = full_convs;
      end
   end
   assign tail_pad = pair_off & full_lanes[0];
endmodule

// *** core/cesh_top.sv ***
// register bank: channel pair enables and 64B/66B sync word select
// assumes host drives one-cycle strobes; read data one cycle later
`include "cesh_regs.svh"
module cesh_top #(
   parameter int CNT_W = 4
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic [`CESH_ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic link_format_64b66b,
   input wire logic [CNT_W-1:0] full_lanes,
   input wire logic [CNT_W-1:0] full_convs,
   output cesh_pkg::cesh_chan_s chan_en,
   output cesh_pkg::cesh_shape_s link_shape,
   output cesh_pkg::cesh_word_e sync_word,
   output logic [`CESH_SYNC_WORD_W-1:0] cmd_field
);
   import cesh_pkg::*;
   // refuse widths the shape struct cannot carry
   if (CNT_W != 4) begin : g_bad_width
      $error("cesh_top supports CNT_W of 4 only");
   end
   logic [7:0] channel_pair_enable_q; // pair enables register
   logic [7:0] sync_header_select_q; // sync select register
   logic [CNT_W-1:0] lanes_w; // derived lane count
   logic [CNT_W-1:0] convs_w; // derived converter count
   logic tail_w; // derived tail flag
   logic first_pair_enable; // a/b field
   logic second_pair_enable; // c/d field
   logic lone_channel_mode; // single channel field
   logic pair_off; // either pair disabled
   assign first_pair_enable = channel_pair_enable_q[`CESH_BIT_FIRST];
   assign second_pair_enable = channel_pair_enable_q[`CESH_BIT_SECOND];
   assign lone_channel_mode = channel_pair_enable_q[`CESH_BIT_LONE];
   assign pair_off = ~first_pair_enable | ~second_pair_enable;
   // pair enable register writes; reserved bits stay zero
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         channel_pair_enable_q <= `CESH_RST_PAIR;
      end else if (clk_en && wr_stb && addr == `CESH_OFF_PAIR) begin
         channel_pair_enable_q <= wdata & `CESH_PAIR_MASK;
      end
   end
   // sync select register writes; reserved bits stay zero
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync_header_select_q <= `CESH_RST_SYNC;
      end else if (clk_en && wr_stb && addr == `CESH_OFF_SYNC) begin
         sync_header_select_q <= wdata & `CESH_SYNC_MASK;
      end
   end
   // read path, unmapped reads zero
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (clk_en) begin
         if (rd_stb && addr == `CESH_OFF_PAIR) begin
            rdata <= channel_pair_enable_q;
         end else if (rd_stb && addr == `CESH_OFF_SYNC) begin
            rdata <= sync_header_select_q;
         end else begin
            rdata <= 8'h00;
         end
      end
   end
   // channel enables from the pair bits
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         chan_en <= 4'hf;
      end else if (clk_en) begin
         chan_en.ch_a <= first_pair_enable;
         // lone channel kills b, c, d
         chan_en.ch_b <= first_pair_enable & ~lone_channel_mode;
         chan_en.ch_c <= second_pair_enable & ~lone_channel_mode;
         chan_en.ch_d <= second_pair_enable & ~lone_channel_mode;
      end
   end
   // lane / converter scaling helper
   cesh_shape #(.CNT_W(CNT_W)) u_shape (
      .full_lanes(full_lanes),
      .full_convs(full_convs),
      .pair_off(pair_off),
      .lanes(lanes_w),
      .convs(convs_w),
      .tail_pad(tail_w)
   );
   // registered link shape
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         link_shape <= '0;
      end else if (clk_en) begin
         link_shape.lanes <= lanes_w;
         link_shape.convs <= convs_w;
         link_shape.tail_pad <= tail_w;
         link_shape.swap_cd <= ~first_pair_enable;
      end
   end
   // sync word content
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sync_word <= CESH_WORD_NONE;
      end else if (clk_en) begin
         if (!link_format_64b66b) begin
            sync_word <= CESH_WORD_NONE;
         end else begin
            case (sync_header_select_q[1:0])
               `CESH_SH_CRC: sync_word <= CESH_WORD_CRC;
               `CESH_SH_FEC: sync_word <= CESH_WORD_FEC;
               default: sync_word <= CESH_WORD_NONE;
            endcase
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      cmd_field <= '0;
   end
endmodule

// *** testbench/cesh_rx_model.sv ***
// link side model: format setting and full-mode counts
// assumes the bench requests format changes between tests
module cesh_rx_model #(parameter int LX = 3, parameter int MX = 4) (
   input wire logic ref_clk,
   input wire logic fmt_req,
   output logic link_format_64b66b,
   output logic [3:0] full_lanes,
   output logic [3:0] full_convs
);
   assign full_lanes = 4'(LX); // odd lane count forces tail bits while a pair is off
   assign full_convs = 4'(MX);
   always_ff @(posedge ref_clk) link_format_64b66b <= fmt_req;
endmodule

// *** testbench/cesh_top_properties.sv ***
// checker on the cesh_top ports, bound into every instance
// assumes one clock, sync active-low reset, full counts held steady
`include "cesh_regs.svh"
module cesh_top_properties import cesh_pkg::*; #(
   parameter int CNT_W = 4
) (
   input wire logic ref_clk, nrst, clk_en, wr_stb, rd_stb, link_format_64b66b,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata, rdata,
   input wire logic [CNT_W-1:0] full_lanes, full_convs,
   input cesh_chan_s chan_en,
   input cesh_shape_s link_shape,
   input cesh_word_e sync_word,
   input wire logic [31:0] cmd_field
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   logic wp, ws; // pair / sync write taken
   logic [7:0] wd_q, wd2_q; // write data one and two edges back
   assign wp = wr_stb && clk_en && addr == `CESH_OFF_PAIR;
   assign ws = wr_stb && clk_en && addr == `CESH_OFF_SYNC;
   // delay line for the written value
   always_ff @(posedge ref_clk) begin
      wd_q <= wdata;
      wd2_q <= wd_q;
   end
   sequence pw; wp ##1 clk_en && !wr_stb; endsequence
   a_cmd_zero: assert property (cmd_field == 32'h0)
      else $error("command field not zero");
   a_sync_ignore: assert property (!link_format_64b66b && clk_en
      |=> sync_word == CESH_WORD_NONE) else $error("sync select used");
   a_sync_map: assert property (ws ##1 clk_en && link_format_64b66b
      && !wr_stb |=> sync_word == (wd2_q[1:0] == 2'h0 ? CESH_WORD_CRC :
      wd2_q[1:0] == 2'h2 ? CESH_WORD_FEC : CESH_WORD_NONE))
      else $error("sync word wrong");
   a_chan_gate: assert property (pw |=> chan_en ==
      {{2{wd2_q[1] & !wd2_q[2]}}, wd2_q[0] & !wd2_q[2], wd2_q[0]})
      else $error("channel enables wrong");
   a_shape_half: assert property (wp && wdata[1:0] != 2'h3 ##1
      clk_en && !wr_stb |=> link_shape.tail_pad == full_lanes[0] &&
      link_shape.lanes == (full_lanes >> 1) + full_lanes[0] &&
      link_shape.convs == full_convs >> 1) else $error("half shape wrong");
   a_shape_swap: assert property (pw |=> link_shape.swap_cd == !wd2_q[0])
      else $error("sample swap wrong");
   a_shape_full: assert property (wp && wdata[1:0] == 2'h3 ##1
      clk_en && !wr_stb |=> link_shape.lanes == full_lanes &&
      !link_shape.tail_pad) else $error("full shape wrong");
   a_read_unmap: assert property (rd_stb && clk_en &&
      addr != `CESH_OFF_PAIR && addr != `CESH_OFF_SYNC |=> rdata == 8'h0)
      else $error("unmapped read not zero");
   cover property (wp && wdata[2]);
   cover property (ws && wdata[1:0] == 2'h2);
   cover property (rd_stb && addr == `CESH_OFF_SYNC);
endmodule
bind cesh_top cesh_top_properties #(.CNT_W(CNT_W)) cesh_top_properties_i (.*);

// *** testbench/channel_enable_sync_header_cfg_bench.sv ***
// bench: pair-enable rows, then sync select and readback cases
// assumes cesh_rx_model supplies format and full counts
module channel_enable_sync_header_cfg_bench import cesh_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0, fmt_req = 1;
   logic clk_en = 1; // freeze control, exercised below
   logic [11:0] addr = 12'h0;
   logic [7:0] wdata = 8'h0, rdata;
   logic link_format_64b66b;
   logic [3:0] full_lanes, full_convs;
   logic [31:0] cmd_field;
   cesh_chan_s chan_en;
   cesh_shape_s link_shape;
   cesh_word_e sync_word;
   int n_errors = 0, n_tests = 0;
   // write value, enables d..a, lanes, convs, tail, swap
   logic [21:0] rows [4] = '{{8'h03, 4'hf, 4'h3, 4'h4, 2'b00},
      {8'h01, 4'h3, 4'h2, 4'h2, 2'b10}, {8'h02, 4'hc, 4'h2, 4'h2, 2'b11},
      {8'h05, 4'h1, 4'h2, 4'h2, 2'b10}};
   always #10 ref_clk = ~ref_clk;
   cesh_top cesh_top_i (.*);
   cesh_rx_model cesh_rx_model_i (.*);
   task chk(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_stb <= 1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_stb <= 0;
      @(posedge ref_clk);
      #1;
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      rd_stb <= 1;
      addr <= a;
      @(posedge ref_clk);
      rd_stb <= 0;
      #1 chk(rdata, e);
   endtask
   task close_out;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      nrst <= 1;
      rd(12'h209, 8'h03);
      rd(12'h20f, 8'h00);
      rd(12'h20a, 8'h00);
      $display("reset test done");
      // lone row keeps first pair, no row clears both
      for (int i = 0; i < 4; i++) begin
         wr(12'h209, rows[i][21:14]);
         chk(chan_en, rows[i][13:10]);
         chk(link_shape, rows[i][9:0]);
      end
      $display("pair rows done");
      // frozen clock enable must drop a write
      @(posedge ref_clk);
      clk_en <= 0;
      wr(12'h209, 8'h01);
      @(posedge ref_clk);
      clk_en <= 1;
      rd(12'h209, 8'h05);
      chk(chan_en, 4'h1);
      $display("freeze test done");
      for (int i = 0; i < 4; i++) begin
         wr(12'h20f, 8'(i));
         chk(sync_word, i == 0 ? CESH_WORD_CRC : i == 2 ? CESH_WORD_FEC :
            CESH_WORD_NONE);
      end
      @(posedge ref_clk);
      fmt_req <= 0;
      repeat (3) @(posedge ref_clk);
      #1 chk(sync_word, CESH_WORD_NONE);
      chk(cmd_field, 32'h0);
      rd(12'h20f, 8'h03);
      $display("sync test done");
      // mid-run reset restores register defaults
      @(posedge ref_clk);
      nrst <= 0;
      @(posedge ref_clk);
      nrst <= 1;
      rd(12'h209, 8'h03);
      chk(chan_en, 4'hf);
      rd(12'h20f, 8'h00);
      $display("reset rerun done");
      close_out;
   end
   // whole run is under 100 cycles; this is many times that
   initial begin
      #50us;
      n_errors++;
      close_out;
   end
endmodule
